// File: shared_pin_io_regs.svh
`ifndef SHARED_PIN_IO_REGS_SVH
`define SHARED_PIN_IO_REGS_SVH

// ****************************************************************
// Register byte offsets on the APB slave.
// ****************************************************************
`define REG_DIRECTION 8'h00
`define REG_LATCH 8'h04
`define REG_LEVEL 8'h08
`define REG_OPEN_DRAIN 8'h0c
`define REG_CN_ENABLE 8'h10
`define REG_CN_PULLUP 8'h14
`define REG_ANALOG 8'h18
`define REG_REMAP 8'h1c
`define REG_CN_STATUS 8'h20

// ****************************************************************
// Reset values and fixed masks.
// ****************************************************************
`define IMPL_MASK 16'h7fff
`define DIRECTION_RESET 16'hffff
`define ZERO_VEC 16'h0000
`define ZERO_WORD 32'h0000_0000
`define PORT_HI 16
`define CN_FLAG_BIT 0

`endif

// File: shared_pin_io_pkg.sv
package shared_pin_io_pkg;

  // One bit per port pin.
  typedef logic [15:0] port_vec_t;

  // APB data word.
  typedef logic [31:0] apb_word_t;

endpackage

// File: shared_pin_io_port.sv
`timescale 1ns/1ns
`include "shared_pin_io_regs.svh"

// Function
// R1: An actively driving enabled peripheral turns off the port driver; pin stays readable.
// R2: An enabled but idle peripheral lets the port bit drive the pin.
// R3: The port's own output never feeds the input of a sharing peripheral.
// R4: Direction bit 1 makes an input with driver off, 0 an output.
// R5: Reset sets every direction bit so all pins come up as inputs.
// R6: Latch register reads back stored latch; writes update the latch.
// R7: Level register reads pin levels; writes update the output latch.
// R8: Unimplemented bits are disabled; latch, direction and level read zero.
// R9: Open-drain select bit makes the pin drive low only, release high.
// R10: Level reads return zero for every pin set as analog input.
// R11: Software sets direction to input on analog pins.
// R12: Software waits one instruction between port write and port read.
// R13: Any enabled change-notify input changing state raises an interrupt request.
// R14: Change detection still works in Sleep with clocks stopped, to wake.
// R15: Each change-notify pin has a pull-up enable switching on a weak pull-up.
// R16: Software turns off pull-ups on pins used as digital outputs.
// R17: A pin shared only with input functions acts as a dedicated port.
// R18: Remappable peripherals reach no pin until software assigns one.
// R19: A fixed peripheral always appears on its default pin when active; the code gives that pin to an active remapped peripheral instead.
// R20: Pin levels are synchronised before port reads and change detection.
// R21: Change compares with prior sample; request holds until software clears.
module shared_pin_io_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire shared_pin_io_pkg::apb_word_t pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire shared_pin_io_pkg::port_vec_t pin_in,
  output shared_pin_io_pkg::port_vec_t pin_out,
  output shared_pin_io_pkg::port_vec_t pin_oe,
  output shared_pin_io_pkg::port_vec_t pullup_en,
  input wire shared_pin_io_pkg::port_vec_t fixed_enable,
  input wire shared_pin_io_pkg::port_vec_t fixed_drive,
  input wire shared_pin_io_pkg::port_vec_t fixed_out,
  input wire shared_pin_io_pkg::port_vec_t remap_drive,
  input wire shared_pin_io_pkg::port_vec_t remap_out,
  output shared_pin_io_pkg::port_vec_t periph_in,
  input wire logic sleep,
  output logic change_irq,
  output logic wake
);

  // ****************************************************************
  // Register state.
  // ****************************************************************
  shared_pin_io_pkg::port_vec_t pin_direction_reg;
  shared_pin_io_pkg::port_vec_t output_latch_reg;
  shared_pin_io_pkg::port_vec_t open_drain_select_reg;
  shared_pin_io_pkg::port_vec_t change_irq_enable;
  shared_pin_io_pkg::port_vec_t change_pullup_enable;
  shared_pin_io_pkg::port_vec_t analog_select;
  shared_pin_io_pkg::port_vec_t remappable_pin;
  shared_pin_io_pkg::port_vec_t next_pin_direction_reg;
  shared_pin_io_pkg::port_vec_t next_output_latch_reg;
  shared_pin_io_pkg::port_vec_t next_open_drain_select_reg;
  shared_pin_io_pkg::port_vec_t next_change_irq_enable;
  shared_pin_io_pkg::port_vec_t next_change_pullup_enable;
  shared_pin_io_pkg::port_vec_t next_analog_select;
  shared_pin_io_pkg::port_vec_t next_remappable_pin;
  logic [31:0] next_prdata;
  logic change_flag;
  logic next_change_flag;

  // ****************************************************************
  // Pin synchronisers and change detection.
  // ****************************************************************
  shared_pin_io_pkg::port_vec_t sync1;
  shared_pin_io_pkg::port_vec_t sync2;
  shared_pin_io_pkg::port_vec_t sync3;
  shared_pin_io_pkg::port_vec_t pin_level_reg;
  shared_pin_io_pkg::port_vec_t next_pin_level_reg;
  shared_pin_io_pkg::port_vec_t changed;

  // ****************************************************************
  // Pin drive.
  // ****************************************************************
  shared_pin_io_pkg::port_vec_t remap_act;
  shared_pin_io_pkg::port_vec_t fixed_act;
  shared_pin_io_pkg::port_vec_t port_owns;
  shared_pin_io_pkg::port_vec_t drive_val;
  shared_pin_io_pkg::port_vec_t drive_en;
  shared_pin_io_pkg::port_vec_t next_pin_out;
  shared_pin_io_pkg::port_vec_t next_pin_oe;

  logic wr_access;
  logic rd_setup;
  logic addr_ok;
  shared_pin_io_pkg::port_vec_t impl_mask;

  // Zero wait states: every access phase completes in its first cycle.
  assign pready = 1'b1;
  // Mask as a vector so each pin slice takes exactly its own bit.
  assign impl_mask = `IMPL_MASK;
  assign wr_access = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // Decode of the mapped words; anything else answers with an error.
  always_comb begin
    unique case (paddr)
      `REG_DIRECTION, `REG_LATCH, `REG_LEVEL, `REG_OPEN_DRAIN,
      `REG_CN_ENABLE, `REG_CN_PULLUP, `REG_ANALOG, `REG_REMAP,
      `REG_CN_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addr_ok;

  // Next register values; unimplemented bits are forced to zero so they
  // can never be stored, driven or read back.
  always_comb begin
    next_pin_direction_reg = pin_direction_reg;
    next_output_latch_reg = output_latch_reg;
    next_open_drain_select_reg = open_drain_select_reg;
    next_change_irq_enable = change_irq_enable;
    next_change_pullup_enable = change_pullup_enable;
    next_analog_select = analog_select;
    next_remappable_pin = remappable_pin;
    if (wr_access) begin
      unique case (paddr)
        `REG_DIRECTION: next_pin_direction_reg =
          pwdata[`PORT_HI-1:0] & `IMPL_MASK; // R4 R8
        `REG_LATCH, `REG_LEVEL: next_output_latch_reg =
          pwdata[`PORT_HI-1:0] & `IMPL_MASK; // R6 R7
        `REG_OPEN_DRAIN: next_open_drain_select_reg =
          pwdata[`PORT_HI-1:0] & `IMPL_MASK; // R9
        `REG_CN_ENABLE: next_change_irq_enable =
          pwdata[`PORT_HI-1:0] & `IMPL_MASK; // R13
        `REG_CN_PULLUP: next_change_pullup_enable =
          pwdata[`PORT_HI-1:0] & `IMPL_MASK; // R15
        `REG_ANALOG: next_analog_select =
          pwdata[`PORT_HI-1:0] & `IMPL_MASK;
        `REG_REMAP: next_remappable_pin =
          pwdata[`PORT_HI-1:0] & `IMPL_MASK; // R18
        default: ;
      endcase
    end
  end

  // Read data is captured in the setup cycle so it comes from a flop.
  always_comb begin
    next_prdata = prdata;
    if (rd_setup) begin
      next_prdata = `ZERO_WORD;
      unique case (paddr)
        `REG_DIRECTION: next_prdata[`PORT_HI-1:0] = pin_direction_reg;
        `REG_LATCH: next_prdata[`PORT_HI-1:0] = output_latch_reg; // R6
        `REG_LEVEL: next_prdata[`PORT_HI-1:0] =
          pin_level_reg & ~analog_select & `IMPL_MASK; // R7 R8 R10
        `REG_OPEN_DRAIN: next_prdata[`PORT_HI-1:0] = open_drain_select_reg;
        `REG_CN_ENABLE: next_prdata[`PORT_HI-1:0] = change_irq_enable;
        `REG_CN_PULLUP: next_prdata[`PORT_HI-1:0] = change_pullup_enable;
        `REG_ANALOG: next_prdata[`PORT_HI-1:0] = analog_select;
        `REG_REMAP: next_prdata[`PORT_HI-1:0] = remappable_pin;
        `REG_CN_STATUS: next_prdata[`CN_FLAG_BIT] = change_flag;
        default: ;
      endcase
    end
  end

  // A pin counts as changed once the second and third stages agree, which
  // filters a single-cycle metastable settle.
  always_comb begin
    next_pin_level_reg = ((sync2 ~^ sync3) & sync3) |
                         ((sync2 ^ sync3) & pin_level_reg); // R20
    changed = (next_pin_level_reg ^ pin_level_reg) &
              change_irq_enable & `IMPL_MASK; // R21
  end

  // Sticky request, write one to clear; a change in the clearing cycle
  // wins so no event is lost.
  always_comb begin
    next_change_flag = change_flag;
    if (wr_access && paddr == `REG_CN_STATUS && pwdata[`CN_FLAG_BIT]) begin
      next_change_flag = 1'b0;
    end
    if (|changed) begin
      next_change_flag = 1'b1; // R13 R21
    end
  end

  // Per-pin output ownership. A remapped peripheral outranks a fixed one;
  // an idle peripheral hands the pin back to the port. Open-drain pins
  // only ever pull low, so a high is a released driver.
  for (genvar i = 0; i < `PORT_HI; i++) begin : g_pin
    assign remap_act[i] = remappable_pin[i] & remap_drive[i]; // R18
    assign fixed_act[i] = fixed_enable[i] & fixed_drive[i]; // R19
    assign port_owns[i] = ~remap_act[i] & ~fixed_act[i]; // R1 R2 R17
    assign drive_val[i] = remap_act[i] ? remap_out[i] :
                          fixed_act[i] ? fixed_out[i] : output_latch_reg[i];
    assign drive_en[i] = port_owns[i] ? ~pin_direction_reg[i] : 1'b1; // R4
    assign next_pin_oe[i] = drive_en[i] & impl_mask[i] &
                            ~(open_drain_select_reg[i] & drive_val[i]); // R9
    assign next_pin_out[i] = next_pin_oe[i] & drive_val[i];
    // The peripheral never sees a level that the port itself is driving.
    assign periph_in[i] = pin_level_reg[i] &
                          ~(port_owns[i] & pin_oe[i]); // R3
  end

  // Weak pull-ups are a plain function of their enables.
  assign pullup_en = change_pullup_enable & `IMPL_MASK; // R15
  assign change_irq = change_flag;

  // In Sleep the clock is gone, so the raw pin is compared against the last
  // stable level without any flop in the path.
  assign wake = sleep & |((pin_in ^ pin_level_reg) &
                          change_irq_enable & `IMPL_MASK); // R14

  // ****************************************************************
  // Registers.
  // ****************************************************************
  // All state: pins come up as undriven inputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_reg <= `DIRECTION_RESET & `IMPL_MASK; // R5
      output_latch_reg <= `ZERO_VEC;
      open_drain_select_reg <= `ZERO_VEC;
      change_irq_enable <= `ZERO_VEC;
      change_pullup_enable <= `ZERO_VEC;
      analog_select <= `ZERO_VEC;
      remappable_pin <= `ZERO_VEC;
      prdata <= `ZERO_WORD;
      change_flag <= 1'b0;
      sync1 <= `ZERO_VEC;
      sync2 <= `ZERO_VEC;
      sync3 <= `ZERO_VEC;
      pin_level_reg <= `ZERO_VEC;
      pin_out <= `ZERO_VEC;
      pin_oe <= `ZERO_VEC;
    end else begin
      pin_direction_reg <= next_pin_direction_reg;
      output_latch_reg <= next_output_latch_reg;
      open_drain_select_reg <= next_open_drain_select_reg;
      change_irq_enable <= next_change_irq_enable;
      change_pullup_enable <= next_change_pullup_enable;
      analog_select <= next_analog_select;
      remappable_pin <= next_remappable_pin;
      prdata <= next_prdata;
      change_flag <= next_change_flag;
      sync1 <= pin_in; // R20
      sync2 <= sync1;
      sync3 <= sync2;
      pin_level_reg <= next_pin_level_reg;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  dir_reset_a: assert property ( // R5
    !$past(presetn) |-> pin_direction_reg == (`DIRECTION_RESET & `IMPL_MASK))
    else $error("direction not all inputs after reset");

  periph_owns_a: assert property ( // R1
    ((pin_out ^ $past(remap_out)) & $past(remap_act & ~open_drain_select_reg)
     & `IMPL_MASK) == `ZERO_VEC)
    else $error("remapped peripheral does not own its pin");

  port_drive_a: assert property ( // R2
    ((pin_oe ^ ~$past(pin_direction_reg)) & $past(port_owns &
     ~open_drain_select_reg) & `IMPL_MASK) == `ZERO_VEC)
    else $error("idle peripheral pin not driven by port");

  loop_block_a: assert property ( // R3
    (periph_in & port_owns & pin_oe) == `ZERO_VEC)
    else $error("port output loops into peripheral");

  level_write_a: assert property ( // R7
    wr_access && paddr == `REG_LEVEL |=>
    output_latch_reg == ($past(pwdata[`PORT_HI-1:0]) & `IMPL_MASK))
    else $error("level write missed the latch");

  unimpl_zero_a: assert property ( // R8
    ((pin_direction_reg | output_latch_reg | pin_oe) & ~`IMPL_MASK)
    == `ZERO_VEC)
    else $error("unimplemented bit is live");

  drain_high_a: assert property ( // R9
    (pin_oe & pin_out & $past(open_drain_select_reg)) == `ZERO_VEC)
    else $error("open-drain pin drives high");

  analog_read_a: assert property ( // R10
    rd_setup && paddr == `REG_LEVEL |=>
    (prdata[`PORT_HI-1:0] & $past(analog_select)) == `ZERO_VEC)
    else $error("analog pin reads non-zero");

  change_irq_a: assert property ( // R13
    |changed |=> change_irq ##1 (change_irq ||
    $past(wr_access && paddr == `REG_CN_STATUS && pwdata[`CN_FLAG_BIT])))
    else $error("enabled change did not raise request");

  irq_hold_a: assert property ( // R21
    change_irq && !(wr_access && paddr == `REG_CN_STATUS) |=> change_irq)
    else $error("request dropped without clear");

  pullup_a: assert property ( // R15
    pullup_en == (change_pullup_enable & `IMPL_MASK))
    else $error("pull-up does not follow enable");

endmodule

// File: pin_partner.sv
`timescale 1ns/1ns

// ****************************************************************
// Pad circuitry outside the port.
// ****************************************************************
module pin_partner (
  input wire logic pclk,
  input wire shared_pin_io_pkg::port_vec_t pin_out,
  input wire shared_pin_io_pkg::port_vec_t pin_oe,
  input wire shared_pin_io_pkg::port_vec_t pullup_en,
  input wire shared_pin_io_pkg::port_vec_t ext_oe,
  input wire shared_pin_io_pkg::port_vec_t ext_val,
  output shared_pin_io_pkg::port_vec_t pin_in
);
  shared_pin_io_pkg::port_vec_t float_q = 16'h5a5a;

  // A floating pad wanders every cycle, so a stale level is never trusted.
  always @(posedge pclk) begin
    float_q <= ~float_q;
  end

  // The port's own drive wins; a released pad with a pull-up reads high.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) |
    (~pin_oe & ~ext_oe & (pullup_en | float_q));
endmodule

// File: test_shared_pin_io_port.sv
`timescale 1ns/1ns
`include "shared_pin_io_regs.svh"

// ****************************************************************
// Stimulus and checking.
// ****************************************************************
module test_shared_pin_io_port;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic sleep = 1'b0;
  logic pready, pslverr, change_irq, wake, err;
  logic [31:0] prdata, rd;
  logic [31:0] rnd = 32'h4b3e2eca;
  shared_pin_io_pkg::apb_word_t pwdata = 32'h0000_0000;
  shared_pin_io_pkg::port_vec_t pin_in, pin_out, pin_oe, pullup_en, periph_in;
  shared_pin_io_pkg::port_vec_t fen = 16'h0000, fdr = 16'h0000;
  shared_pin_io_pkg::port_vec_t fo = 16'h0000, rdr = 16'h0000;
  shared_pin_io_pkg::port_vec_t ro = 16'h0000, ext = 16'h0000;
  shared_pin_io_pkg::port_vec_t xoe = 16'hffff;
  shared_pin_io_pkg::port_vec_t dir, lat, od, rsel, pu, an, own_r, own_f;
  shared_pin_io_pkg::port_vec_t lvl, en;
  int errors = 0;
  int checked = 0;

  // Free-running 8 ns clock.
  always #4 pclk = ~pclk;

  shared_pin_io_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .fixed_enable(fen), .fixed_drive(fdr), .fixed_out(fo),
    .remap_drive(rdr), .remap_out(ro), .periph_in(periph_in),
    .sleep(sleep), .change_irq(change_irq), .wake(wake));

  pin_partner u_pads (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_oe(xoe), .ext_val(ext),
    .pin_in(pin_in));

  // Next random half-word; the shift register state lives in rnd.
  function automatic shared_pin_io_pkg::port_vec_t rnd16();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[23:8];
  endfunction

  // Value the owner puts on each pad: remap first, then fixed, then latch.
  function automatic shared_pin_io_pkg::port_vec_t pad_val();
    return (own_r & ro) | (own_f & ~own_r & fo) | (~own_r & ~own_f & lat);
  endfunction

  // Open drain releases a high level whoever owns the pad.
  function automatic shared_pin_io_pkg::port_vec_t pad_oe();
    return (own_r | own_f | ~dir) & ~(od & pad_val()) & `IMPL_MASK;
  endfunction

  task automatic cmp_word(input shared_pin_io_pkg::apb_word_t g,
                          input shared_pin_io_pkg::apb_word_t e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_pins(input shared_pin_io_pkg::port_vec_t g,
                          input shared_pin_io_pkg::port_vec_t e);
    cmp_word({16'h0000, g}, {16'h0000, e});
  endtask

  task automatic conclude();
    $display("Comparisons %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One APB transfer; the leading edge keeps psel low between transfers.
  task automatic apb(input logic w, input logic [7:0] a,
                     input shared_pin_io_pkg::apb_word_t d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      errors++;
      conclude();
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Main sequence: reset, register and pad mixes, then change notify.
  initial begin
    idle(16);
    presetn <= 1'b1;
    apb(1'b0, `REG_DIRECTION, 32'h0);
    cmp_word(rd, 32'h0000_7fff);
    cmp_pins(pin_oe, 16'h0000);
    apb(1'b0, 8'h24, 32'h0);
    cmp_word({rd[31:1], err}, 32'h1);
    for (int k = 0; k < 12; k++) begin
      dir = (k < 2) ? 16'h0000 : rnd16();
      lat = rnd16();
      od = (k == 1) ? 16'hffff : ((k == 0) ? 16'h0000 : rnd16());
      rsel = rnd16();
      pu = rnd16() & dir;
      fen <= (k < 2) ? 16'h0000 : rnd16();
      fdr <= rnd16();
      fo <= rnd16();
      rdr <= (k < 2) ? 16'h0000 : rnd16();
      ro <= rnd16();
      ext <= rnd16();
      // The far side lets go only of pads that have a pull-up to hold them.
      xoe <= ~(rnd16() & pu & `IMPL_MASK);
      apb(1'b1, `REG_DIRECTION, {16'h0, dir});
      apb(1'b1, k[0] ? `REG_LEVEL : `REG_LATCH, {16'h0, lat});
      apb(1'b1, `REG_OPEN_DRAIN, {16'h0, od});
      apb(1'b1, `REG_CN_PULLUP, {16'h0, pu});
      apb(1'b1, `REG_REMAP, {16'h0, rsel});
      apb(1'b0, `REG_LATCH, 32'h0);
      cmp_word(rd, {16'h0, lat & `IMPL_MASK});
      apb(1'b0, `REG_DIRECTION, 32'h0);
      cmp_word(rd, {16'h0, dir & `IMPL_MASK});
      idle(8);
      own_r = rsel & rdr;
      own_f = fen & fdr;
      // A pad that nobody drives sits at its pull-up level.
      lvl = ((pad_oe() & pad_val()) | (~pad_oe() & xoe & ext) |
             (~pad_oe() & ~xoe)) & `IMPL_MASK;
      cmp_pins(pin_oe, pad_oe());
      cmp_pins(pin_out, pad_val() & pad_oe());
      cmp_pins(periph_in & `IMPL_MASK,
               lvl & ~(pad_oe() & ~own_r & ~own_f));
      cmp_pins(pullup_en, pu & `IMPL_MASK);
      apb(1'b0, `REG_LEVEL, 32'h0);
      cmp_word(rd, {16'h0, lvl});
      an = rnd16() & dir;
      apb(1'b1, `REG_ANALOG, {16'h0, an});
      apb(1'b0, `REG_LEVEL, 32'h0);
      cmp_word(rd, {16'h0, lvl & ~an});
      apb(1'b1, `REG_ANALOG, 32'h0);
    end
    en = 16'h0001 << (rnd16() % 15);
    // Peripherals let go of every pad so the watched pin follows the far side.
    fen <= 16'h0000;
    rdr <= 16'h0000;
    xoe <= 16'hffff;
    apb(1'b1, `REG_DIRECTION, 32'h0000_ffff);
    apb(1'b1, `REG_CN_ENABLE, {16'h0, en});
    idle(8);
    apb(1'b1, `REG_CN_STATUS, 32'h1);
    idle(2);
    cmp_word({31'h0, change_irq}, 32'h0);
    ext <= ext ^ (~en & `IMPL_MASK);
    idle(8);
    cmp_word({31'h0, change_irq}, 32'h0);
    ext <= ext ^ en;
    idle(8);
    cmp_word({31'h0, change_irq}, 32'h1);
    idle(20);
    apb(1'b0, `REG_CN_STATUS, 32'h0);
    cmp_word(rd, 32'h1);
    apb(1'b1, `REG_CN_STATUS, 32'h1);
    idle(2);
    cmp_word({30'h0, change_irq, wake}, 32'h0);
    sleep <= 1'b1;
    @(posedge pclk);
    ext <= ext ^ en;
    @(posedge pclk);
    cmp_word({31'h0, wake}, 32'h1);
    idle(8);
    sleep <= 1'b0;
    conclude();
  end
endmodule
